// [hdl/locc_regs.vh]
// register map, field limits and timing constants of the control block
`ifndef LOCC_REGS_VH
`define LOCC_REGS_VH

// byte offsets, capture block high address bits and capture word codes
`define LOCC_A_CMD        8'h00
`define LOCC_A_OFS_SEL    8'h04
`define LOCC_A_OFS_DATA   8'h08
`define LOCC_A_OUT_CTRL   8'h0c
`define LOCC_A_STATUS     8'h10
`define LOCC_A_CAP_HI     3'h1
`define LOCC_CAP_STEP     2'h0
`define LOCC_CAP_LEN      2'h1
`define LOCC_CAP_CFG      2'h2
`define LOCC_CAP_STAT     2'h3

// command opcodes
`define LOCC_OP_SAVE      4'h1
`define LOCC_OP_RECALL    4'h2
`define LOCC_OP_GAIN      4'h3
`define LOCC_OP_RESERVE   4'h4
`define LOCC_OP_PHASE     4'h5
`define LOCC_OP_SCALE     4'h6
`define LOCC_OP_START     4'h7
`define LOCC_OP_PAUSE     4'h8
`define LOCC_OP_CLEAR     4'h9

// field limits
`define LOCC_QTY_MAX      5'h13
`define LOCC_QTY_PER_OUT  6'h14
`define LOCC_OFS_DEPTH    40
`define LOCC_OFS_MIN      16'hd8f0
`define LOCC_OFS_MAX      16'h2710
`define LOCC_EXP_MIN      9'h001
`define LOCC_EXP_MAX      9'h100
`define LOCC_OUT_SRC_MAX  6'h21
`define LOCC_SRC_A_MAG    6'h00
`define LOCC_SRC_A_QUAD   6'h02
`define LOCC_SRC_B_MAG    6'h11
`define LOCC_SRC_B_QUAD   6'h13
`define LOCC_SLOT_USER    4'h4
`define LOCC_SLOT_DEFAULT 4'h5
`define LOCC_STEP_MIN     17'h00001
`define LOCC_STEP_MAX     17'h186a0
`define LOCC_LEN_MIN      15'h0001
`define LOCC_LEN_MAX      15'h4000
`define LOCC_BUF_SRC_MAX  5'h15
`define LOCC_SETUP_W      122

// factory defaults held in slot five
`define LOCC_DEF_OUT1     6'h00
`define LOCC_DEF_OUT2     6'h11
`define LOCC_DEF_STEP     17'h003e8
`define LOCC_DEF_LEN      15'h4000

// status bits
`define LOCC_ST_ERR       0
`define LOCC_ST_PHSKIP    1

// bus answers
`define LOCC_RESP_OKAY    2'b00
`define LOCC_RESP_SLVERR  2'b10

// timing
`define LOCC_MS_NS        1000000
`define LOCC_CLK_NS       4

`endif

// [hdl/locc_mem.v]
// small table memory with registered read data
`timescale 1ns/1ps

module locc_mem #(
  parameter W     = 25,
  parameter DEPTH = 40,
  parameter AW    = 6
) (
  // clock and reset
  input  wire          i_clk,
  input  wire          i_rst_b,
  // write port
  input  wire          i_we,
  input  wire [AW-1:0] i_waddr,
  input  wire [W-1:0]  i_wdata,
  // read port
  input  wire [AW-1:0] i_raddr,
  output reg  [W-1:0]  o_rdata
);

  reg [W-1:0] mem [0:DEPTH-1];

  always @(posedge i_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rdata <= {W{1'b0}};
    end else begin
      o_rdata <= mem[i_raddr];
    end
  end

endmodule // locc_mem

// [hdl/locc_top.v]
// output offset/expand, setup slots, auto functions and capture control
`timescale 1ns/1ps
`include "locc_regs.vh"

// How it works
// - offset/expand entries exist per output for quantities 0 to 19
// - offset accepted only from -100.00 to +100.00 percent, in hundredths
// - expand accepted only from 1 to 256
// - readback returns offset in low half, then expand above it
// - each output has an update mode: 0 slow, 1 fast
// - fast mode forces a non magnitude/in-phase/quadrature source to magnitude
// - save copies the setup except the offset/expand entries into user slot 1 to 4, kept without reset
// - recall loads slot 1 to 4, or factory defaults from slot 5
// - auto gain, reserve, phase and scale pulse per selected channel
// - auto phase sends no pulse on a channel whose phase is unstable and sets the phase-skip status bit
// - step time per channel is 1 to 100000 ms in 1 ms steps
// - capture length per channel is at most 16384 samples
// - each channel's four buffers each pick a source 0 to 21
// - trigger select per channel: 0 internal, 1 external
// - capture mode per channel: 0 single pass, 1 loop
// - start code 1, 2 or 3 runs channel A, B or both
// - pause uses the same codes and suspends capture
// - clear empties all four buffers of each selected channel
// - after a clear the stored-point count reads zero
module locc_top #(
  parameter MS_CYCLES = `LOCC_MS_NS / `LOCC_CLK_NS
) (
  // clock and reset
  input  wire        I_REF_CLK,
  input  wire        I_RST_B,
  // axi4-lite write channels
  input  wire [31:0] I_AWADDR,
  input  wire        I_AWVALID,
  output wire        O_AWREADY,
  input  wire [31:0] I_WDATA,
  input  wire [3:0]  I_WSTRB,
  input  wire        I_WVALID,
  output wire        O_WREADY,
  output wire [1:0]  O_BRESP,
  output wire        O_BVALID,
  input  wire        I_BREADY,
  // axi4-lite read channels
  input  wire [31:0] I_ARADDR,
  input  wire        I_ARVALID,
  output wire        O_ARREADY,
  output wire [31:0] O_RDATA,
  output wire [1:0]  O_RRESP,
  output wire        O_RVALID,
  input  wire        I_RREADY,
  // measurement side
  input  wire [1:0]  I_PHASE_UNSTABLE,
  input  wire [1:0]  I_EXT_TRIG,
  // auto functions, one bit per channel
  output wire [1:0]  O_AUTO_GAIN,
  output wire [1:0]  O_AUTO_RESERVE,
  output wire [1:0]  O_AUTO_PHASE,
  output wire [1:0]  O_AUTO_SCALE,
  // analog outputs
  output wire [5:0]  O_OUT1_SRC,
  output wire [5:0]  O_OUT2_SRC,
  output wire [1:0]  O_OUT_FAST,
  output wire        O_OFS_UPD,
  output wire [5:0]  O_OFS_IDX,
  output wire [15:0] O_OFS_VAL,
  output wire [8:0]  O_EXP_VAL,
  // capture buffers
  output wire [1:0]  O_CAP_WE,
  output wire [1:0]  O_CAP_CLR,
  output wire [13:0] O_CAP_ADDR_A,
  output wire [13:0] O_CAP_ADDR_B,
  output wire [19:0] O_CAP_SRC_A,
  output wire [19:0] O_CAP_SRC_B
);

  // bus slave state
  reg        awready_r;
  reg        wready_r;
  reg        bvalid_r;
  reg [1:0]  bresp_r;
  reg        arready_r;
  reg        rvalid_r;
  reg [1:0]  rresp_r;
  reg [31:0] rdata_r;
  reg [31:0] aw_addr_r;
  reg        aw_full_r;
  reg [31:0] wdata_r;
  reg [3:0]  wstrb_r;
  reg        w_full_r;

  // configuration
  reg [5:0]  out_src1_r;
  reg [5:0]  out_src2_r;
  reg [1:0]  speed_r;
  reg [1:0]  trig_r;
  reg [1:0]  mode_r;
  reg [33:0] step_r;
  reg [29:0] len_r;
  reg [39:0] src_r;
  reg [4:0]  ofs_qty_r;
  reg        ofs_out_r;
  reg [1:0]  status_r;
  reg [`LOCC_SETUP_W-1:0] slot_r [0:3];

  // command pulses
  reg [1:0]  gain_r;
  reg [1:0]  resv_r;
  reg [1:0]  phase_r;
  reg [1:0]  scale_r;
  reg [1:0]  start_r;
  reg [1:0]  pause_r;
  reg [1:0]  clr_r;
  reg        ofs_upd_r;
  reg [5:0]  ofs_idx_r;
  reg [15:0] ofs_val_r;
  reg [8:0]  exp_val_r;

  // millisecond tick
  reg [17:0] ms_cnt_r;
  reg        ms_tick_r;

  wire [1:0]  cap_run;
  wire [29:0] cap_cnt;
  wire [1:0]  cap_we;
  wire [1:0]  cap_clr;
  wire [27:0] cap_addr;
  wire [24:0] ofs_rdata;

  // write decode
  wire        wr_fire  = aw_full_r & w_full_r & ~bvalid_r;
  wire        wa_low   = (aw_addr_r[31:8] == 24'h0) & (aw_addr_r[1:0] == 2'b00);
  wire [7:0]  wa       = aw_addr_r[7:0];
  wire        hit_cmd  = wa_low & (wa == `LOCC_A_CMD);
  wire        hit_osel = wa_low & (wa == `LOCC_A_OFS_SEL);
  wire        hit_odat = wa_low & (wa == `LOCC_A_OFS_DATA);
  wire        hit_octl = wa_low & (wa == `LOCC_A_OUT_CTRL);
  wire        hit_stat = wa_low & (wa == `LOCC_A_STATUS);
  wire        hit_cap  = wa_low & (wa[7:5] == `LOCC_A_CAP_HI);
  wire        cap_ch   = wa[4];
  wire [1:0]  cap_sub  = wa[3:2];
  wire        wr_map   = hit_cmd | hit_osel | hit_odat | hit_octl | hit_stat
                       | (hit_cap & (cap_sub != `LOCC_CAP_STAT));
  // partial-word writes are refused rather than merged
  wire        wr_ok    = wr_fire & wr_map & (wstrb_r == 4'hf);

  wire [3:0]  cmd_op   = wdata_r[3:0];
  wire [3:0]  cmd_arg  = wdata_r[7:4];
  wire [1:0]  cmd_mask = cmd_arg[1:0];
  wire        ch_ok    = (cmd_arg != 4'h0) & (cmd_arg <= 4'h3);
  wire        do_cmd   = wr_ok & hit_cmd;
  wire        save_ok  = (cmd_arg != 4'h0) & (cmd_arg <= `LOCC_SLOT_USER);
  wire        rcl_ok   = (cmd_arg != 4'h0) & (cmd_arg <= `LOCC_SLOT_DEFAULT);
  wire [1:0]  slot_idx = cmd_arg[1:0] - 2'd1;
  wire        op_save  = do_cmd & (cmd_op == `LOCC_OP_SAVE);
  wire        op_rcl   = do_cmd & (cmd_op == `LOCC_OP_RECALL);
  wire        op_chan  = do_cmd & (cmd_op >= `LOCC_OP_GAIN) & (cmd_op <= `LOCC_OP_CLEAR);
  wire        cmd_bad  = (op_save & ~save_ok) | (op_rcl & ~rcl_ok) | (op_chan & ~ch_ok)
                       | (do_cmd & ((cmd_op == 4'h0) | (cmd_op > `LOCC_OP_CLEAR)));

  // offset and expand arrive in one word, so a pair is never half written
  wire [15:0] new_ofs  = wdata_r[15:0];
  wire [8:0]  new_exp  = wdata_r[24:16];
  wire        ofs_in   = ($signed(new_ofs) >= $signed(`LOCC_OFS_MIN))
                       & ($signed(new_ofs) <= $signed(`LOCC_OFS_MAX));
  wire        exp_in   = (new_exp >= `LOCC_EXP_MIN) & (new_exp <= `LOCC_EXP_MAX);
  wire        odat_ok  = ofs_in & exp_in & (wdata_r[31:25] == 7'h0);
  wire        ofs_we   = wr_ok & hit_odat & odat_ok;
  wire        osel_ok  = wdata_r[4:0] <= `LOCC_QTY_MAX;
  wire [5:0]  ofs_addr = {1'b0, ofs_qty_r} + (ofs_out_r ? `LOCC_QTY_PER_OUT : 6'h00);

  // output source handling
  wire [5:0]  n_src1   = wdata_r[5:0];
  wire [5:0]  n_src2   = wdata_r[13:8];
  wire [1:0]  n_fast   = wdata_r[17:16];
  wire        octl_ok  = (n_src1 <= `LOCC_OUT_SRC_MAX) & (n_src2 <= `LOCC_OUT_SRC_MAX);

  function [5:0] fit_src;
    input [5:0] src;
    input       fast;
    reg         grp_a;
    reg         grp_b;
    begin
      grp_a = src <= `LOCC_SRC_A_QUAD;
      grp_b = (src >= `LOCC_SRC_B_MAG) & (src <= `LOCC_SRC_B_QUAD);
      if (fast & ~grp_a & ~grp_b) begin
        fit_src = (src >= `LOCC_SRC_B_MAG) ? `LOCC_SRC_B_MAG : `LOCC_SRC_A_MAG;
      end else begin
        fit_src = src;
      end
    end
  endfunction

  // capture settings checks
  wire        step_ok  = (wdata_r[31:17] == 15'h0) & (wdata_r[16:0] >= `LOCC_STEP_MIN)
                       & (wdata_r[16:0] <= `LOCC_STEP_MAX);
  wire        len_ok   = (wdata_r[31:15] == 17'h0) & (wdata_r[14:0] >= `LOCC_LEN_MIN)
                       & (wdata_r[14:0] <= `LOCC_LEN_MAX);
  wire        cfg_ok   = (wdata_r[9:5] <= `LOCC_BUF_SRC_MAX) & (wdata_r[14:10] <= `LOCC_BUF_SRC_MAX)
                       & (wdata_r[19:15] <= `LOCC_BUF_SRC_MAX)
                       & (wdata_r[24:20] <= `LOCC_BUF_SRC_MAX);
  wire        cap_bad  = hit_cap & (((cap_sub == `LOCC_CAP_STEP) & ~step_ok)
                       | ((cap_sub == `LOCC_CAP_LEN) & ~len_ok)
                       | ((cap_sub == `LOCC_CAP_CFG) & ~cfg_ok));
  wire        val_bad  = wr_ok & ((hit_odat & ~odat_ok) | (hit_osel & ~osel_ok)
                       | (hit_octl & ~octl_ok) | cap_bad);
  wire        err_set  = val_bad | cmd_bad;
  wire        skip_set = op_chan & ch_ok & (cmd_op == `LOCC_OP_PHASE)
                       & ((cmd_mask & I_PHASE_UNSTABLE) != 2'b00);

  wire [`LOCC_SETUP_W-1:0] setup_now = {out_src1_r, out_src2_r, speed_r, trig_r, mode_r,
                                        step_r, len_r, src_r};
  wire [`LOCC_SETUP_W-1:0] setup_def = {`LOCC_DEF_OUT1, `LOCC_DEF_OUT2, 2'b00, 2'b00, 2'b00,
                                        `LOCC_DEF_STEP, `LOCC_DEF_STEP,
                                        `LOCC_DEF_LEN, `LOCC_DEF_LEN, 40'h0};
  wire [`LOCC_SETUP_W-1:0] setup_rcl = (cmd_arg == `LOCC_SLOT_DEFAULT) ? setup_def
                                                                       : slot_r[slot_idx];

  // bus handshakes
  always @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      aw_full_r <= 1'b0;
      w_full_r  <= 1'b0;
      aw_addr_r <= 32'h0;
      wdata_r   <= 32'h0;
      wstrb_r   <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= `LOCC_RESP_OKAY;
    end else begin
      if (I_AWVALID & awready_r) begin
        aw_addr_r <= I_AWADDR;
        aw_full_r <= 1'b1;
        awready_r <= 1'b0;
      end
      if (I_WVALID & wready_r) begin
        wdata_r  <= I_WDATA;
        wstrb_r  <= I_WSTRB;
        w_full_r <= 1'b1;
        wready_r <= 1'b0;
      end
      if (wr_fire) begin
        aw_full_r <= 1'b0;
        w_full_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= wr_ok ? `LOCC_RESP_OKAY : `LOCC_RESP_SLVERR;
      end else if (bvalid_r & I_BREADY) begin
        bvalid_r  <= 1'b0;
        awready_r <= 1'b1;
        wready_r  <= 1'b1;
      end
    end
  end

  // read mux, sampled at the address handshake
  reg [31:0] rd_mux;
  reg        rd_hit;
  always @* begin
    rd_mux = 32'h0;
    rd_hit = (I_ARADDR[31:8] == 24'h0) & (I_ARADDR[1:0] == 2'b00);
    if (I_ARADDR[7:5] == `LOCC_A_CAP_HI) begin
      case (I_ARADDR[3:2])
        `LOCC_CAP_STEP: rd_mux = {15'h0, step_r[17*I_ARADDR[4] +: 17]};
        `LOCC_CAP_LEN:  rd_mux = {17'h0, len_r[15*I_ARADDR[4] +: 15]};
        `LOCC_CAP_CFG:  rd_mux = {7'h0, src_r[20*I_ARADDR[4] +: 20], 3'h0,
                                  mode_r[I_ARADDR[4]], trig_r[I_ARADDR[4]]};
        default:        rd_mux = {15'h0, cap_run[I_ARADDR[4]], 1'b0,
                                  cap_cnt[15*I_ARADDR[4] +: 15]};
      endcase
    end else begin
      case (I_ARADDR[7:0])
        `LOCC_A_CMD:      rd_mux = 32'h0;
        `LOCC_A_OFS_SEL:  rd_mux = {23'h0, ofs_out_r, 3'h0, ofs_qty_r};
        `LOCC_A_OFS_DATA: rd_mux = {7'h0, ofs_rdata};
        `LOCC_A_OUT_CTRL: rd_mux = {14'h0, speed_r, 2'h0, out_src2_r, 2'h0, out_src1_r};
        `LOCC_A_STATUS:   rd_mux = {30'h0, status_r};
        default:          rd_hit = 1'b0;
      endcase
    end
  end

  always @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rresp_r   <= `LOCC_RESP_OKAY;
      rdata_r   <= 32'h0;
    end else if (I_ARVALID & arready_r) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b1;
      rdata_r   <= rd_hit ? rd_mux : 32'h0;
      rresp_r   <= rd_hit ? `LOCC_RESP_OKAY : `LOCC_RESP_SLVERR;
    end else if (rvalid_r & I_RREADY) begin
      rvalid_r  <= 1'b0;
      arready_r <= 1'b1;
    end
  end

  // setup slots have no reset so they survive like the nonvolatile store
  always @(posedge I_REF_CLK) begin
    if (op_save & save_ok) begin
      slot_r[slot_idx] <= setup_now;
    end
  end

  // configuration registers
  always @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      {out_src1_r, out_src2_r, speed_r, trig_r, mode_r, step_r, len_r, src_r} <=
        {`LOCC_DEF_OUT1, `LOCC_DEF_OUT2, 2'b00, 2'b00, 2'b00, `LOCC_DEF_STEP, `LOCC_DEF_STEP,
         `LOCC_DEF_LEN, `LOCC_DEF_LEN, 40'h0};
      ofs_qty_r <= 5'h0;
      ofs_out_r <= 1'b0;
      status_r  <= 2'b00;
    end else begin
      if (op_rcl & rcl_ok) begin
        {out_src1_r, out_src2_r, speed_r, trig_r, mode_r, step_r, len_r, src_r} <= setup_rcl;
      end
      if (wr_ok & hit_osel & osel_ok) begin
        ofs_qty_r <= wdata_r[4:0];
        ofs_out_r <= wdata_r[8];
      end
      if (wr_ok & hit_octl & octl_ok) begin
        speed_r    <= n_fast;
        out_src1_r <= fit_src(n_src1, n_fast[0]);
        out_src2_r <= fit_src(n_src2, n_fast[1]);
      end
      if (wr_ok & hit_cap & step_ok & (cap_sub == `LOCC_CAP_STEP)) begin
        step_r[17*cap_ch +: 17] <= wdata_r[16:0];
      end
      if (wr_ok & hit_cap & len_ok & (cap_sub == `LOCC_CAP_LEN)) begin
        len_r[15*cap_ch +: 15] <= wdata_r[14:0];
      end
      if (wr_ok & hit_cap & cfg_ok & (cap_sub == `LOCC_CAP_CFG)) begin
        trig_r[cap_ch]         <= wdata_r[0];
        mode_r[cap_ch]         <= wdata_r[1];
        src_r[20*cap_ch +: 20] <= wdata_r[24:5];
      end
      // a new event beats a write-one-to-clear in the same cycle
      status_r[`LOCC_ST_ERR]    <= err_set | (status_r[`LOCC_ST_ERR]
                                   & ~(wr_ok & hit_stat & wdata_r[`LOCC_ST_ERR]));
      status_r[`LOCC_ST_PHSKIP] <= skip_set | (status_r[`LOCC_ST_PHSKIP]
                                   & ~(wr_ok & hit_stat & wdata_r[`LOCC_ST_PHSKIP]));
    end
  end

  // command pulses and offset update strobe
  always @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      {gain_r, resv_r, phase_r, scale_r, start_r, pause_r, clr_r} <= 14'h0;
      ofs_upd_r <= 1'b0;
      ofs_idx_r <= 6'h0;
      ofs_val_r <= 16'h0;
      exp_val_r <= 9'h0;
    end else begin
      gain_r  <= (op_chan & ch_ok & (cmd_op == `LOCC_OP_GAIN))    ? cmd_mask : 2'b00;
      resv_r  <= (op_chan & ch_ok & (cmd_op == `LOCC_OP_RESERVE)) ? cmd_mask : 2'b00;
      scale_r <= (op_chan & ch_ok & (cmd_op == `LOCC_OP_SCALE))   ? cmd_mask : 2'b00;
      phase_r <= (op_chan & ch_ok & (cmd_op == `LOCC_OP_PHASE))
                 ? (cmd_mask & ~I_PHASE_UNSTABLE) : 2'b00;
      start_r <= (op_chan & ch_ok & (cmd_op == `LOCC_OP_START))   ? cmd_mask : 2'b00;
      pause_r <= (op_chan & ch_ok & (cmd_op == `LOCC_OP_PAUSE))   ? cmd_mask : 2'b00;
      clr_r   <= (op_chan & ch_ok & (cmd_op == `LOCC_OP_CLEAR))   ? cmd_mask : 2'b00;
      ofs_upd_r <= ofs_we;
      if (ofs_we) begin
        ofs_idx_r <= ofs_addr;
        ofs_val_r <= new_ofs;
        exp_val_r <= new_exp;
      end
    end
  end

  // millisecond enable for internal stepping
  always @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      ms_cnt_r  <= 18'h0;
      ms_tick_r <= 1'b0;
    end else begin
      ms_tick_r <= (ms_cnt_r == MS_CYCLES[17:0] - 18'd1);
      ms_cnt_r  <= (ms_cnt_r == MS_CYCLES[17:0] - 18'd1) ? 18'h0 : ms_cnt_r + 18'd1;
    end
  end

  locc_mem #(
    .W     (25),
    .DEPTH (`LOCC_OFS_DEPTH),
    .AW    (6)
  ) u_ofs_mem (
    .i_clk   (I_REF_CLK),
    .i_rst_b (I_RST_B),
    .i_we    (ofs_we),
    .i_waddr (ofs_addr),
    .i_wdata ({new_exp, new_ofs}),
    .i_raddr (ofs_addr),
    .o_rdata (ofs_rdata)
  );

  // per-channel capture engines
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_cap
      reg         run_r;
      reg  [13:0] ptr_r;
      reg  [14:0] cnt_r;
      reg  [16:0] stp_r;
      reg         we_r;
      reg         clr_o_r;
      reg  [13:0] addr_r;
      wire [16:0] step_g = step_r[17*g +: 17];
      wire [14:0] len_g  = len_r[15*g +: 15];
      wire        last_g = ({1'b0, ptr_r} + 15'd1) >= len_g;
      wire        full_g = ~mode_r[g] & (cnt_r >= len_g);
      wire        due_g  = ms_tick_r & ((stp_r + 17'd1) >= step_g);
      wire        samp_g = run_r & ~full_g
                         & (trig_r[g] ? I_EXT_TRIG[g] : due_g);

      always @(posedge I_REF_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
          run_r   <= 1'b0;
          ptr_r   <= 14'h0;
          cnt_r   <= 15'h0;
          stp_r   <= 17'h0;
          we_r    <= 1'b0;
          clr_o_r <= 1'b0;
          addr_r  <= 14'h0;
        end else begin
          we_r    <= samp_g;
          clr_o_r <= clr_r[g];
          if (clr_r[g]) begin
            ptr_r <= 14'h0;
            cnt_r <= 15'h0;
            stp_r <= 17'h0;
          end else begin
            if (run_r & ms_tick_r & ~trig_r[g]) begin
              stp_r <= due_g ? 17'h0 : stp_r + 17'd1;
            end
            if (samp_g) begin
              addr_r <= ptr_r;
              ptr_r  <= last_g ? 14'h0 : ptr_r + 14'd1;
              if (cnt_r < len_g) begin
                cnt_r <= cnt_r + 15'd1;
              end
            end
          end
          // pause only drops run, so pointer and count carry over to the next start
          if (pause_r[g]) begin
            run_r <= 1'b0;
          end else if (start_r[g]) begin
            run_r <= 1'b1;
          end else if ((samp_g & last_g & ~mode_r[g]) | (run_r & full_g)) begin
            run_r <= 1'b0;
          end
        end
      end

      assign cap_run[g]          = run_r;
      assign cap_cnt[15*g +: 15] = cnt_r;
      assign cap_we[g]           = we_r;
      assign cap_clr[g]          = clr_o_r;
      assign cap_addr[14*g +: 14] = addr_r;
    end
  endgenerate

  // outputs
  assign O_AWREADY      = awready_r;
  assign O_WREADY       = wready_r;
  assign O_BRESP        = bresp_r;
  assign O_BVALID       = bvalid_r;
  assign O_ARREADY      = arready_r;
  assign O_RDATA        = rdata_r;
  assign O_RRESP        = rresp_r;
  assign O_RVALID       = rvalid_r;
  assign O_AUTO_GAIN    = gain_r;
  assign O_AUTO_RESERVE = resv_r;
  assign O_AUTO_PHASE   = phase_r;
  assign O_AUTO_SCALE   = scale_r;
  assign O_OUT1_SRC     = out_src1_r;
  assign O_OUT2_SRC     = out_src2_r;
  assign O_OUT_FAST     = speed_r;
  assign O_OFS_UPD      = ofs_upd_r;
  assign O_OFS_IDX      = ofs_idx_r;
  assign O_OFS_VAL      = ofs_val_r;
  assign O_EXP_VAL      = exp_val_r;
  assign O_CAP_WE       = cap_we;
  assign O_CAP_CLR      = cap_clr;
  assign O_CAP_ADDR_A   = cap_addr[13:0];
  assign O_CAP_ADDR_B   = cap_addr[27:14];
  assign O_CAP_SRC_A    = src_r[19:0];
  assign O_CAP_SRC_B    = src_r[39:20];

endmodule // locc_top

// [testbench/locc_top_chk.sv]
// port checker of the control block
`timescale 1ns/1ps
module locc_chk (
  // clock, reset, bus answer and offset update strobe
  input logic       I_REF_CLK, I_RST_B, I_BREADY, O_BVALID, O_OFS_UPD,
  // pulses and levels
  input logic [1:0] O_BRESP, I_PHASE_UNSTABLE, O_AUTO_GAIN, O_AUTO_PHASE, O_OUT_FAST, O_CAP_CLR,
  // offset and expand entry
  input logic [5:0] O_OFS_IDX,
  input logic [15:0] O_OFS_VAL,
  input logic [8:0] O_EXP_VAL
);
  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RST_B);
  sequence s_ack;
    O_BVALID;
  endsequence
  sequence s_gain_gone;
    ##1 O_AUTO_GAIN == 2'h0;
  endsequence
  property p_gain;
    O_AUTO_GAIN != 2'h0 |-> s_ack and s_gain_gone;
  endproperty
  a_gain: assert property (p_gain) else $error("gain pulse");
  property p_phase;
    (O_AUTO_PHASE & $past(I_PHASE_UNSTABLE)) == 2'h0;
  endproperty
  a_phase: assert property (p_phase) else $error("phase on unstable");
  property p_clr;
    O_CAP_CLR != 2'h0 |-> $past(O_BVALID) ##1 O_CAP_CLR == 2'h0;
  endproperty
  a_clr: assert property (p_clr) else $error("clear pulse");
  property p_ofs;
    O_OFS_UPD |-> $signed(O_OFS_VAL) >= -10000 && $signed(O_OFS_VAL) <= 10000;
  endproperty
  a_ofs: assert property (p_ofs) else $error("offset range");
  property p_exp;
    O_OFS_UPD |-> O_EXP_VAL >= 9'h001 && O_EXP_VAL <= 9'h100;
  endproperty
  a_exp: assert property (p_exp) else $error("expand range");
  property p_idx;
    O_OFS_UPD |-> O_OFS_IDX < 6'h28;
  endproperty
  a_idx: assert property (p_idx) else $error("entry index");
  property p_fast;
    !$stable(O_OUT_FAST) |-> O_BVALID;
  endproperty
  a_fast: assert property (p_fast) else $error("mode change without write");
  property p_bdone;
    O_BVALID && I_BREADY |=> !O_BVALID;
  endproperty
  a_bdone: assert property (p_bdone) else $error("write answer held");
endmodule // locc_chk

bind locc_top locc_chk u_locc_chk (.*);

// [testbench/locc_host.sv]
// host model issuing register bus transfers
`timescale 1ns/1ps
module locc_host (
  // clock
  input  logic        clk,
  // requests
  output logic [31:0] awaddr = 0, wdata = 0, araddr = 0,
  output logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0,
  output logic [3:0]  wstrb = 4'hf,
  // answers
  input  logic        awready, wready, bvalid, arready, rvalid,
  input  logic [1:0]  bresp, rresp,
  input  logic [31:0] rdata
);
  // offset and expand go out in one word, never split
  task automatic wr(input logic [31:0] a, d, output logic [1:0] r);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    forever begin
      @(posedge clk);
      // released payload is scrambled to catch stale use
      if (awready) begin awvalid <= 1'b0; awaddr <= ~a; end
      if (wready) begin wvalid <= 1'b0; wdata <= ~d; end
      if (bvalid) begin r = bresp; bready <= 1'b0; break; end
    end
  endtask
  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    forever begin
      @(posedge clk);
      if (arready) begin arvalid <= 1'b0; araddr <= ~a; end
      if (rvalid) begin d = rdata; rready <= 1'b0; @(posedge clk); break; end
    end
  endtask
endmodule // locc_host

// [testbench/test_locc_top.sv]
// self-checking bench of the control block
`timescale 1ns/1ps
`include "locc_regs.vh"
module test_locc_top;
  logic I_REF_CLK = 0, I_RST_B = 0, I_AWVALID, I_WVALID, I_BREADY, I_ARVALID, I_RREADY;
  logic O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID, O_OFS_UPD;
  logic [31:0] I_AWADDR, I_WDATA, I_ARADDR, O_RDATA, d;
  logic [3:0]  I_WSTRB;
  logic [1:0]  O_BRESP, O_RRESP, I_PHASE_UNSTABLE = 0, I_EXT_TRIG = 0, r;
  logic [1:0]  O_AUTO_GAIN, O_AUTO_RESERVE, O_AUTO_PHASE, O_AUTO_SCALE, O_OUT_FAST;
  logic [1:0]  O_CAP_WE, O_CAP_CLR;
  logic [5:0]  O_OUT1_SRC, O_OUT2_SRC, O_OFS_IDX;
  logic [15:0] O_OFS_VAL;
  logic [8:0]  O_EXP_VAL;
  logic [13:0] O_CAP_ADDR_A, O_CAP_ADDR_B, last_a = 0;
  logic [19:0] O_CAP_SRC_A, O_CAP_SRC_B;
  logic [7:0]  seen = 0;
  logic        seen_clr = 0;
  int          we_n = 0, mismatches = 0, check_count = 0;
  initial forever #2 I_REF_CLK = ~I_REF_CLK;
  always @(posedge I_REF_CLK) begin
    seen <= seen_clr ? 8'h00 : seen | {O_AUTO_GAIN, O_AUTO_RESERVE, O_AUTO_PHASE, O_AUTO_SCALE};
    if (O_CAP_WE[0]) begin we_n <= we_n + 1; last_a <= O_CAP_ADDR_A; end
  end
  locc_top #(.MS_CYCLES(10)) u_locc_top (.*);
  locc_host u_locc_host (.clk(I_REF_CLK), .awaddr(I_AWADDR), .wdata(I_WDATA), .araddr(I_ARADDR),
    .awvalid(I_AWVALID), .wvalid(I_WVALID), .bready(I_BREADY), .arvalid(I_ARVALID),
    .rready(I_RREADY), .wstrb(I_WSTRB), .awready(O_AWREADY), .wready(O_WREADY), .bvalid(O_BVALID),
    .arready(O_ARREADY), .rvalid(O_RVALID), .bresp(O_BRESP), .rresp(O_RRESP), .rdata(O_RDATA));
  task ck(input logic ok, input string m);
    check_count++;
    if (ok !== 1'b1) begin mismatches++; $display("MISMATCH %0t %s", $time, m); end
  endtask
  // one edge after the answer so registered effects have landed
  task w(input logic [31:0] a, dd);
    u_locc_host.wr(a, dd, r);
    @(posedge I_REF_CLK);
  endtask
  task trig;
    I_EXT_TRIG <= 2'h1;
    @(posedge I_REF_CLK);
    I_EXT_TRIG <= 2'h0;
    repeat (3) @(posedge I_REF_CLK);
  endtask
  task test_ofs;
    w(`LOCC_A_OFS_SEL, 32'h113);
    w(`LOCC_A_OFS_DATA, 32'h0100d8f0);
    ck(O_OFS_IDX === 6'h27 && O_OFS_VAL === 16'hd8f0 && O_EXP_VAL === 9'h100, "entry");
    w(`LOCC_A_OFS_DATA, 32'h01010000); ck(O_EXP_VAL === 9'h100, "expand 257");
    w(`LOCC_A_OFS_DATA, 32'h0001d8ef); ck(O_OFS_VAL === 16'hd8f0, "offset low");
    u_locc_host.rd(`LOCC_A_OFS_DATA, d); ck(d === 32'h0100d8f0, "readback");
    u_locc_host.rd(`LOCC_A_STATUS, d); ck(d[0] === 1'b1, "error flag");
    w(`LOCC_A_STATUS, 32'h3);
    w(32'h40, 32'h0); ck(r === `LOCC_RESP_SLVERR, "unmapped");
    $display("test_ofs done");
  endtask
  task test_out;
    w(`LOCC_A_OUT_CTRL, 32'h00011103); ck(O_OUT1_SRC === 6'h00 && O_OUT_FAST === 2'h1, "fast1");
    w(`LOCC_A_OUT_CTRL, 32'h00021402); ck(O_OUT2_SRC === 6'h11 && O_OUT1_SRC === 6'h02, "fast2");
    w(`LOCC_A_CMD, 32'h11);
    w(`LOCC_A_OUT_CTRL, 32'h00000505);
    w(`LOCC_A_CMD, 32'h12); ck(O_OUT1_SRC === 6'h02 && O_OUT_FAST === 2'h2, "slot 1");
    w(`LOCC_A_CMD, 32'h52); ck(O_OUT2_SRC === 6'h11 && O_OUT_FAST === 2'h0, "defaults");
    $display("test_out done");
  endtask
  task test_auto;
    I_PHASE_UNSTABLE <= 2'h1;
    for (int op = 3; op <= 6; op++) begin
      seen_clr <= 1'b1;
      @(posedge I_REF_CLK);
      seen_clr <= 1'b0;
      w(`LOCC_A_CMD, 32'h30 | op);
      // let the outputs settle after each auto command before checking
      repeat (20) @(posedge I_REF_CLK);
      ck(seen === (op == 5 ? 8'h08 : 8'h03 << (2 * (6 - op))), "auto pulses");
    end
    u_locc_host.rd(`LOCC_A_STATUS, d); ck(d[1] === 1'b1, "phase skipped");
    $display("test_auto done");
  endtask
  task test_cap;
    w(32'h24, 32'h2);
    w(32'h28, 32'h1);
    w(`LOCC_A_CMD, 32'h17);
    repeat (3) trig;
    ck(we_n === 2 && last_a === 14'h1, "single stop");
    u_locc_host.rd(32'h2c, d); ck(d[16:0] === 17'h2, "count");
    w(`LOCC_A_CMD, 32'h19); u_locc_host.rd(32'h2c, d); ck(d[14:0] === 15'h0, "cleared");
    w(32'h28, 32'h2a3); ck(O_CAP_SRC_A === 20'h15, "source");
    w(`LOCC_A_CMD, 32'h17);
    trig;
    w(`LOCC_A_CMD, 32'h18);
    trig; ck(we_n === 3 && last_a === 14'h0, "paused");
    w(`LOCC_A_CMD, 32'h17);
    trig; ck(we_n === 4 && last_a === 14'h1, "resume");
    trig; ck(we_n === 5 && last_a === 14'h0, "wrap");
    $display("test_cap done");
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge I_REF_CLK);
    I_RST_B <= 1'b1;
    @(posedge I_REF_CLK);
    test_ofs; test_out; test_auto; test_cap;
    test_done;
  end
  initial begin
    repeat (20000) @(posedge I_REF_CLK);
    mismatches++;
    test_done;
  end
endmodule // test_locc_top
